// File: rtl/rsel_cfg.svh
// Constants of the remappable input select bank
`ifndef RSEL_CFG_SVH
`define RSEL_CFG_SVH

// ****************************************************************
// Register byte offsets on the APB bus
// ****************************************************************
`define RSEL_OFF_FAULT    12'h000
`define RSEL_OFF_U3RX     12'h004
`define RSEL_OFF_UART1    12'h008
`define RSEL_OFF_UART2    12'h00c
`define RSEL_OFF_SPICD    12'h010
`define RSEL_OFF_U3SPI1   12'h014
`define RSEL_OFF_T1SPI2   12'h018
`define RSEL_OFF_SPI2SS   12'h01c
`define RSEL_OFF_UART4    12'h020

// ****************************************************************
// Field layout
// ****************************************************************
`define RSEL_REG_COUNT    9
`define RSEL_SLOT_COUNT   18
`define RSEL_FIELD_W      6
`define RSEL_UPPER_LSB    8
`define RSEL_LOWER_LSB    0
`define RSEL_ADDR_W       12
`define RSEL_MAX_PINS     64

// Slot 2*r is the lower field of register r, 2*r+1 the upper one
`define RSEL_SLOT_IMPL    18'h3fffb

// ****************************************************************
// Reset values
// ****************************************************************
`define RSEL_FIELD_RST    6'h3f
`define RSEL_IDLE_LEVEL   1'b0

`endif

// File: rtl/rsel_pkg.sv
// Types of the remappable input select bank
`include "rsel_cfg.svh"

package rsel_pkg;

    typedef logic [`RSEL_FIELD_W-1:0] rsel_field_t;

    typedef struct packed {
        rsel_field_t [`RSEL_SLOT_COUNT-1:0] field;
        logic [`RSEL_MAX_PINS-1:0]          pin_meta;
        logic [`RSEL_MAX_PINS-1:0]          pin_sync;
        logic [`RSEL_SLOT_COUNT-1:0]        route;
        logic [31:0]                        rdata;
    } rsel_state_s;

endpackage

// File: rtl/rsel_bank.sv
// Remappable input select bank with APB register access
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "rsel_cfg.svh"

module rsel_bank
    import rsel_pkg::*;
#(
    parameter int PIN_COUNT = `RSEL_MAX_PINS
) (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    reset_n_i,

    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`RSEL_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic                         pready_o,
    output logic [31:0]                  prdata_o,
    output logic                         pslverr_o,

    // Remappable device pins
    input  wire logic [PIN_COUNT-1:0]    remappable_io_pin_i,

    // Routed peripheral inputs
    output logic                         compare_fault_a_input_o,
    output logic                         compare_fault_b_input_o,
    output logic                         uart1_rx_o,
    output logic                         uart1_cts_o,
    output logic                         uart2_rx_o,
    output logic                         uart2_cts_o,
    output logic                         uart3_rx_o,
    output logic                         uart3_cts_o,
    output logic                         uart4_rx_o,
    output logic                         uart4_cts_o,
    output logic                         spi_clock_o,
    output logic                         spi_data_a_o,
    output logic                         spi_data_b_o,
    output logic                         spi1_select_o,
    output logic                         spi2_select_o,
    output logic                         timer1_clock_o,
    output logic                         spare_route_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // A six-bit field cannot name more than 64 pins
    generate
        if (PIN_COUNT < 1 || PIN_COUNT > `RSEL_MAX_PINS) begin : g_bad
            $error("PIN_COUNT must lie between 1 and 64");
        end
    endgenerate

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int NREG  = `RSEL_REG_COUNT;
    localparam int NSLOT = `RSEL_SLOT_COUNT;
    localparam int FW    = `RSEL_FIELD_W;
    localparam int ULSB  = `RSEL_UPPER_LSB;
    localparam int LLSB  = `RSEL_LOWER_LSB;

    localparam logic [NSLOT-1:0] SLOT_IMPL = `RSEL_SLOT_IMPL;

    localparam logic [NREG-1:0][`RSEL_ADDR_W-1:0] REG_OFF = {
        `RSEL_OFF_UART4,
        `RSEL_OFF_SPI2SS,
        `RSEL_OFF_T1SPI2,
        `RSEL_OFF_U3SPI1,
        `RSEL_OFF_SPICD,
        `RSEL_OFF_UART2,
        `RSEL_OFF_UART1,
        `RSEL_OFF_U3RX,
        `RSEL_OFF_FAULT
    };

    // Fields reset to all ones; the unimplemented slot stays zero
    function automatic rsel_state_s reset_state();
        rsel_state_s s;
        s = '0;
        for (int i = 0; i < NSLOT; i++) begin
            if (SLOT_IMPL[i]) begin
                s.field[i] = `RSEL_FIELD_RST;
            end
        end
        return s;
    endfunction

    localparam rsel_state_s RESET_STATE = reset_state();

    // ****************************************************************
    // State
    // ****************************************************************
    rsel_state_s                state;
    rsel_state_s                next_state;
    logic [`RSEL_MAX_PINS-1:0]  pin_wide;
    logic [NREG-1:0]            reg_hit;
    logic                       any_hit;
    logic                       wr_access;
    logic                       rd_setup;

    // ****************************************************************
    // Pin widening and address decode
    // ****************************************************************
    // Pins beyond PIN_COUNT read as idle and never toggle
    generate
        if (PIN_COUNT < `RSEL_MAX_PINS) begin : g_pad
            assign pin_wide = {
                {(`RSEL_MAX_PINS - PIN_COUNT){`RSEL_IDLE_LEVEL}},
                remappable_io_pin_i
            };
        end else begin : g_full
            assign pin_wide = remappable_io_pin_i;
        end
    endgenerate

    genvar gr;
    generate
        for (gr = 0; gr < NREG; gr++) begin : g_dec
            assign reg_hit[gr] = (paddr_i == REG_OFF[gr]);
        end
    endgenerate

    assign any_hit   = |reg_hit;
    assign wr_access = psel_i & penable_i & pwrite_i & any_hit;
    assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [FW-1:0] sel;
        logic [15:0]   half;
        next_state = state;
        sel        = '0;
        half       = '0;

        // Two-stage synchroniser; only the second stage is read
        next_state.pin_meta = pin_wide;
        next_state.pin_sync = state.pin_meta;

        // Field writes, gated by byte strobe and implemented mask
        if (wr_access) begin
            for (int r = 0; r < NREG; r++) begin
                if (reg_hit[r]) begin
                    if (pstrb_i[1] && SLOT_IMPL[2*r+1]) begin
                        next_state.field[2*r+1] =
                            pwdata_i[ULSB +: FW];
                    end
                    if (pstrb_i[0] && SLOT_IMPL[2*r]) begin
                        next_state.field[2*r] =
                            pwdata_i[LLSB +: FW];
                    end
                end
            end
        end

        // Read data is captured in setup so it stands at access
        if (rd_setup) begin
            next_state.rdata = '0;
            for (int r = 0; r < NREG; r++) begin
                if (reg_hit[r]) begin
                    half = '0;
                    half[ULSB +: FW] = state.field[2*r+1];
                    half[LLSB +: FW] = state.field[2*r];
                    next_state.rdata = {16'h0000, half};
                end
            end
        end

        // Routing: a select beyond the pin count gives idle
        for (int s = 0; s < NSLOT; s++) begin
            sel = state.field[s];
            if (SLOT_IMPL[s] && (int'(sel) < PIN_COUNT)) begin
                next_state.route[s] = state.pin_sync[sel];
            end else begin
                next_state.route[s] = `RSEL_IDLE_LEVEL;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    // Zero wait states; unmapped offsets raise an error
    assign pready_o  = 1'b1;
    assign prdata_o  = state.rdata;
    assign pslverr_o = psel_i & penable_i & ~any_hit;

    // ****************************************************************
    // Routed peripheral inputs
    // ****************************************************************
    // Slot 2*r is the lower field of register r
    assign compare_fault_a_input_o = state.route[0];
    assign compare_fault_b_input_o = state.route[1];
    assign uart3_rx_o              = state.route[3];
    assign uart1_rx_o              = state.route[4];
    assign uart1_cts_o             = state.route[5];
    assign uart2_rx_o              = state.route[6];
    assign uart2_cts_o             = state.route[7];
    assign spi_data_a_o            = state.route[8];
    assign spi_clock_o             = state.route[9];
    assign spi1_select_o           = state.route[10];
    assign uart3_cts_o             = state.route[11];
    assign spi_data_b_o            = state.route[12];
    assign timer1_clock_o          = state.route[13];
    assign spi2_select_o           = state.route[14];
    // Function of this field is unknown; routed but not tied to a user
    assign spare_route_o           = state.route[15];
    assign uart4_rx_o              = state.route[16];
    assign uart4_cts_o             = state.route[17];

endmodule

// File: verif/rsel_pins.sv
// Far-side model: remappable pins driven by an external device
`timescale 1ns/1ps
module rsel_pins #(
    parameter int PIN_COUNT = 64
) (
    // Clock
    input  wire logic                 ref_clk_i,
    // Level the bench wants on each pin
    input  wire logic [PIN_COUNT-1:0] pattern_i,
    // Pin levels
    output logic      [PIN_COUNT-1:0] remappable_io_pin_o = '0
);
    // Pins settle one cycle after the request, as a slow external driver
    always @(posedge ref_clk_i) begin
        remappable_io_pin_o <= pattern_i;
    end
endmodule

// File: verif/rsel_bank_chk.sv
// Assertion checker for the remappable input select bank
`timescale 1ns/1ps
module rsel_bank_chk #(
    parameter int PIN_COUNT = 64
) (
    input wire logic                 ref_clk_i,
    input wire logic                 reset_n_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [11:0]          paddr_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [3:0]           pstrb_i,
    input wire logic                 pready_o,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pslverr_o,
    input wire logic [PIN_COUNT-1:0] remappable_io_pin_i,
    input wire logic                 compare_fault_a_input_o,
    input wire logic                 uart4_rx_o
);
    logic [PIN_COUNT-1:0] pin_d1, pin_d2, pin_d3;
    logic [5:0]           fa_sel, fa_d;
    logic [1:0]           warm;
    wire                  acc = psel_i && penable_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Pin history mirrors the two-flop synchroniser plus the route stage
    always_ff @(posedge ref_clk_i) begin
        pin_d1 <= remappable_io_pin_i;
        pin_d2 <= pin_d1;
        pin_d3 <= pin_d2;
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fa_sel <= 6'h3f;
            fa_d   <= 6'h3f;
            warm   <= 2'h0;
        end else begin
            if (acc && pwrite_i && paddr_i == 12'h000 && pstrb_i[0]) begin
                fa_sel <= pwdata_i[5:0];
            end
            fa_d <= fa_sel;
            if (warm != 2'h3) begin
                warm <= warm + 2'h1;
            end
        end
    end
    a_ready_always: assert property (pready_o)
        else $error("pready low");
    a_err_unmapped: assert property (acc && paddr_i > 12'h020 |->
        pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped not refused");
    a_err_mapped: assert property (acc && paddr_i <= 12'h020 &&
        paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("mapped refused");
    a_rsv_zero: assert property (acc && !pwrite_i |->
        prdata_o[31:14] == 18'h0 && prdata_o[7:6] == 2'h0)
        else $error("reserved bits set");
    a_low_byte_zero: assert property (acc && !pwrite_i &&
        paddr_i == 12'h004 |-> prdata_o[7:0] == 8'h0)
        else $error("uart3 low byte set");
    a_read_hold: assert property (acc && !pwrite_i |=>
        $stable(prdata_o)) else $error("read data moved");
    a_idle_release: assert property ($rose(reset_n_i) |->
        !uart4_rx_o [*2]) else $error("route not idle");
    a_fault_route: assert property (warm == 2'h3 |->
        compare_fault_a_input_o ==
        (fa_d < PIN_COUNT ? pin_d3[fa_d] : 1'b0))
        else $error("fault a route wrong");
    c_write: cover property (acc && pwrite_i);
    c_read: cover property (acc && !pwrite_i);
    c_err: cover property (acc && pslverr_o);
endmodule
bind rsel_bank rsel_bank_chk #(.PIN_COUNT(PIN_COUNT)) rsel_bank_chk_i (
    .ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o,
    .remappable_io_pin_i, .compare_fault_a_input_o, .uart4_rx_o);

// File: verif/remappable_input_select_bank_bench.sv
// Self-checking bench for the remappable input select bank
`timescale 1ns/1ps
module remappable_input_select_bank_bench;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] e;
    } rsel_row_s;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'h0;
    logic        pready_o, pslverr_o, er;
    // Routed inputs indexed by slot; slot 2 has no field behind it
    wire  [17:0] ro;
    assign ro[2] = 1'b0;
    logic [39:0] pattern = '0, pins;
    int          bad_count = 0, checked = 0;
    rsel_row_s   rows [10] = '{
        '{12'h000, 32'hffff_2a15, 4'hf, 32'h2a15},
        '{12'h004, 32'h0000_ffff, 4'hf, 32'h3f00},
        '{12'h008, 32'h0000_0102, 4'hf, 32'h0102},
        '{12'h00c, 32'h0000_0304, 4'hf, 32'h0304},
        '{12'h010, 32'h0000_0506, 4'hf, 32'h0506},
        '{12'h014, 32'h0000_0708, 4'hf, 32'h0708},
        '{12'h018, 32'h0000_090a, 4'hf, 32'h090a},
        '{12'h01c, 32'h0000_0b0c, 4'hf, 32'h0b0c},
        '{12'h020, 32'h0000_0d0e, 4'hf, 32'h0d0e},
        '{12'h008, 32'h0000_3f3f, 4'h1, 32'h013f}};
    always #12.5 ref_clk_i = ~ref_clk_i;
    rsel_pins #(.PIN_COUNT(40)) rsel_pins_i (.ref_clk_i(ref_clk_i),
        .pattern_i(pattern), .remappable_io_pin_o(pins));
    // Fewer pins than field codes, so the idle route is reachable
    rsel_bank #(.PIN_COUNT(40)) rsel_bank_i (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .remappable_io_pin_i(pins),
        .compare_fault_a_input_o(ro[0]), .compare_fault_b_input_o(ro[1]),
        .uart3_rx_o(ro[3]), .uart1_rx_o(ro[4]), .uart1_cts_o(ro[5]),
        .uart2_rx_o(ro[6]), .uart2_cts_o(ro[7]), .spi_data_a_o(ro[8]),
        .spi_clock_o(ro[9]), .spi1_select_o(ro[10]),
        .uart3_cts_o(ro[11]), .spi_data_b_o(ro[12]),
        .timer1_clock_o(ro[13]), .spi2_select_o(ro[14]),
        .spare_route_o(ro[15]), .uart4_rx_o(ro[16]),
        .uart4_cts_o(ro[17]));
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
            chk("reset value", i == 1 ? 32'h3f00 : 32'h3f3f, rd);
        end
        $display("reset values done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            chk("readback", rows[i].e, rd);
        end
        $display("register rows done");
        apb(1'b1, 12'h000, 32'h0000_2d05, 4'h3);
        pattern <= 40'h20;
        repeat (6) @(posedge ref_clk_i);
        chk("fault a high", 32'h1, {31'h0, ro[0]});
        chk("fault b idle", 32'h0, {31'h0, ro[1]});
        pattern <= 40'h0;
        repeat (6) @(posedge ref_clk_i);
        chk("fault a low", 32'h0, {31'h0, ro[0]});
        $display("routing done");
        apb(1'b1, 12'h024, 32'h0, 4'hf);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h024, 32'h0, 4'h0);
        chk("unmapped read", 32'h0, rd);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("fault reg kept", 32'h2d05, rd);
        // Slot s selects pin s+1, then one pin at a time is raised
        for (int r = 0; r < 9; r++) begin
            apb(1'b1, 12'(r * 4), {16'h0, 2'h0, 6'(2 * r + 2), 2'h0,
                6'(2 * r + 1)}, 4'hf);
        end
        for (int s = 0; s < 18; s++) begin
            pattern <= 40'h1 << (s + 1);
            repeat (5) @(posedge ref_clk_i);
            chk("route", s == 2 ? 32'h0 : 32'h1 << s, {14'h0, ro});
        end
        $display("route sweep done");
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("second reset", 32'h3f3f, rd);
        chk("reset routes idle", 32'h0, {14'h0, ro});
        $display("refusal and reset done");
        tally_and_finish();
    end
endmodule
